/* logic/dcbc_top.v */
// DDR3 command decode, per-bank row control and write data path
`timescale 1ns/10ps
`include "dcbc_map.vh"

// ----------------------------------------------------------------
// Write data FIFO
// ----------------------------------------------------------------
module dcbc_fifo #(
	parameter WIDTH = 9,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	// Clock and reset
	input wire i_clk,
	input wire i_reset_n,
	// Fill side
	input wire i_valid,
	output wire o_ready,
	input wire [WIDTH-1:0] i_data,
	// Drain side
	output wire o_valid,
	input wire i_ready,
	output wire [WIDTH-1:0] o_data
);
	reg [WIDTH-1:0] mem_r [0:DEPTH-1];
	reg [AW-1:0] wp_r;
	reg [AW-1:0] rp_r;
	reg [AW:0] cnt_r;
	wire push;
	wire pop;
	localparam [AW:0] FULL = DEPTH;
	assign o_ready = (cnt_r != FULL);
	assign o_valid = (cnt_r != {(AW+1){1'b0}});
	assign o_data = mem_r[rp_r];
	assign push = i_valid & o_ready;
	assign pop = o_valid & i_ready;
	always @(posedge i_clk) begin
		if (!i_reset_n) begin
			wp_r <= {AW{1'b0}};
			rp_r <= {AW{1'b0}};
			cnt_r <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				mem_r[wp_r] <= i_data;
				wp_r <= wp_r + {{(AW-1){1'b0}}, 1'b1};
			end
			if (pop)
				rp_r <= rp_r + {{(AW-1){1'b0}}, 1'b1};
			if (push & ~pop)
				cnt_r <= cnt_r + {{AW{1'b0}}, 1'b1};
			else if (pop & ~push)
				cnt_r <= cnt_r - {{AW{1'b0}}, 1'b1};
		end
	end
endmodule // dcbc_fifo

// ----------------------------------------------------------------
// Top
// ----------------------------------------------------------------
module dcbc_top (
	// Clock and reset
	input wire i_clk,
	input wire i_reset_n,
	// Command pins
	input wire i_cke,
	input wire i_cs_n,
	input wire i_ras_n,
	input wire i_cas_n,
	input wire i_we_n,
	input wire i_odt,
	input wire [`DCBC_BAW-1:0] i_ba,
	input wire [`DCBC_ROWW-1:0] i_addr,
	input wire [3:0] i_al,
	// Write data, one byte per clock here
	input wire [`DCBC_DW-1:0] i_wdata,
	input wire i_dm,
	// Array write port
	output reg o_arr_we,
	output reg [`DCBC_BAW-1:0] o_arr_bank,
	output reg [`DCBC_ROWW-1:0] o_arr_row,
	output reg [`DCBC_COLW-1:0] o_arr_col,
	output reg [`DCBC_DW-1:0] o_arr_data,
	input wire i_arr_ready,
	// Read burst request
	output reg o_rd_go,
	output reg [`DCBC_BAW-1:0] o_rd_bank,
	output reg [`DCBC_ROWW-1:0] o_rd_row,
	output reg [`DCBC_COLW-1:0] o_rd_col,
	output reg o_rd_bl8,
	// Mode register write
	output reg o_mrs_we,
	output reg [1:0] o_mrs_sel,
	output reg [`DCBC_ROWW-1:0] o_mrs_val,
	// Status
	output reg [`DCBC_NBANK-1:0] o_bank_open,
	output reg o_burst_busy,
	output reg o_self_refresh,
	output reg o_power_down,
	output reg o_odt_en,
	output reg o_wr_overflow
);
	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	reg cke_q_r;
	reg sr_r;
	reg pd_r;
	wire [2:0] cmd;
	wire live;
	wire ap;
	wire bl8;
	assign cmd = {i_ras_n, i_cas_n, i_we_n};
	assign live = cke_q_r & i_cke & ~i_cs_n;
	assign ap = i_addr[`DCBC_AP_BIT];
	assign bl8 = i_addr[`DCBC_BC_BIT];
	wire is_mrs = live & (cmd == `DCBC_CMD_MRS);
	wire is_ref = live & (cmd == `DCBC_CMD_REF);
	wire is_pre = live & (cmd == `DCBC_CMD_PRE);
	wire is_act = live & (cmd == `DCBC_CMD_ACT);
	wire is_wr = live & (cmd == `DCBC_CMD_WR);
	wire is_rd = live & (cmd == `DCBC_CMD_RD);
	// NOP and ZQ fall through every decode above untouched

	// ------------------------------------------------------------
	// Power state
	// ------------------------------------------------------------
	// Exit is taken on the first sampled high level; no command is needed
	always @(posedge i_clk) begin
		if (!i_reset_n) begin
			cke_q_r <= 1'b1;
			sr_r <= 1'b0;
			pd_r <= 1'b0;
		end else begin
			cke_q_r <= i_cke;
			if (cke_q_r & ~i_cke & ~i_cs_n & (cmd == `DCBC_CMD_REF))
				sr_r <= 1'b1;
			else if (i_cke)
				sr_r <= 1'b0;
			if (cke_q_r & ~i_cke & ~(~i_cs_n & (cmd == `DCBC_CMD_REF)))
				pd_r <= 1'b1;
			else if (i_cke)
				pd_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Bank machines
	// ------------------------------------------------------------
	reg [1:0] bst_r [0:`DCBC_NBANK-1];
	reg [`DCBC_ROWW-1:0] brow_r [0:`DCBC_NBANK-1];
	reg [3:0] btmr_r [0:`DCBC_NBANK-1];
	reg [4:0] bras_r [0:`DCBC_NBANK-1];
	reg [`DCBC_NBANK-1:0] bap_r;
	reg [`DCBC_NBANK-1:0] bcl_r;
	integer k;

	// Write completion and read timer fire of auto-precharge bursts
	reg wr_ap_done;
	reg [`DCBC_BAW-1:0] wr_ap_bank;
	reg rd_ap_fire;
	reg [`DCBC_BAW-1:0] rd_ap_bank;

	always @(posedge i_clk) begin
		if (!i_reset_n) begin
			for (k = 0; k < `DCBC_NBANK; k = k + 1) begin
				bst_r[k] <= `DCBC_BK_IDLE;
				brow_r[k] <= {`DCBC_ROWW{1'b0}};
				btmr_r[k] <= 4'h0;
				bras_r[k] <= 5'h00;
			end
			bap_r <= {`DCBC_NBANK{1'b0}};
			bcl_r <= {`DCBC_NBANK{1'b0}};
		end else begin
			for (k = 0; k < `DCBC_NBANK; k = k + 1) begin
				if (bras_r[k] != 5'h00)
					bras_r[k] <= bras_r[k] - 5'h01;
				case (bst_r[k])
				`DCBC_BK_IDLE: begin
					if (is_act && i_ba == k[`DCBC_BAW-1:0]) begin
						bst_r[k] <= `DCBC_BK_ACT;
						brow_r[k] <= i_addr;
						bras_r[k] <= `DCBC_TRAS;
					end
				end
				`DCBC_BK_ACT: begin
					if ((is_rd | is_wr) && ap &&
						i_ba == k[`DCBC_BAW-1:0])
						bap_r[k] <= 1'b1;
					// Close request is one cycle wide; keep it for tRAS
					if (bap_r[k] && ((rd_ap_fire &&
						rd_ap_bank == k[`DCBC_BAW-1:0]) ||
						(wr_ap_done &&
						wr_ap_bank == k[`DCBC_BAW-1:0])))
						bcl_r[k] <= 1'b1;
					// Row restore guard applies to every close
					if (bras_r[k] <= 5'h01 &&
						((is_pre && (ap || i_ba == k[`DCBC_BAW-1:0])) ||
						bcl_r[k] ||
						(bap_r[k] && rd_ap_fire &&
						rd_ap_bank == k[`DCBC_BAW-1:0]) ||
						(bap_r[k] && wr_ap_done &&
						wr_ap_bank == k[`DCBC_BAW-1:0]))) begin
						bst_r[k] <= `DCBC_BK_PRE;
						btmr_r[k] <= `DCBC_TRP;
						bap_r[k] <= 1'b0;
						bcl_r[k] <= 1'b0;
					end
				end
				`DCBC_BK_PRE: begin
					// Further precharges here are ignored
					if (btmr_r[k] <= 4'h1)
						bst_r[k] <= `DCBC_BK_IDLE;
					else
						btmr_r[k] <= btmr_r[k] - 4'h1;
				end
				default: bst_r[k] <= `DCBC_BK_IDLE;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Read auto-precharge timer
	// ------------------------------------------------------------
	// One pending read close at a time; a later one replaces it
	reg [4:0] rtp_r;
	reg rtp_busy_r;
	always @(posedge i_clk) begin
		if (!i_reset_n) begin
			rtp_r <= 5'h00;
			rtp_busy_r <= 1'b0;
			rd_ap_bank <= {`DCBC_BAW{1'b0}};
		end else if (is_rd && ap) begin
			rtp_r <= {1'b0, i_al} + {1'b0, `DCBC_TRTP};
			rtp_busy_r <= 1'b1;
			rd_ap_bank <= i_ba;
		end else if (rtp_busy_r) begin
			rtp_r <= rtp_r - 5'h01;
			if (rtp_r <= 5'h01)
				rtp_busy_r <= 1'b0;
		end
	end
	always @* begin
		rd_ap_fire = rtp_busy_r && (rtp_r == 5'h01);
	end

	// ------------------------------------------------------------
	// Read burst launch
	// ------------------------------------------------------------
	always @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_rd_go <= 1'b0;
			o_rd_bank <= {`DCBC_BAW{1'b0}};
			o_rd_row <= {`DCBC_ROWW{1'b0}};
			o_rd_col <= {`DCBC_COLW{1'b0}};
			o_rd_bl8 <= 1'b0;
		end else begin
			o_rd_go <= is_rd;
			if (is_rd) begin
				o_rd_bank <= i_ba;
				o_rd_row <= brow_r[i_ba];
				o_rd_col <= i_addr[`DCBC_COLW-1:0];
				o_rd_bl8 <= bl8;
			end
		end
	end

	// ------------------------------------------------------------
	// Write burst engine
	// ------------------------------------------------------------
	localparam WS_IDLE = 2'h0;
	localparam WS_LAT = 2'h1;
	localparam WS_DATA = 2'h2;
	reg [1:0] ws_r;
	reg [3:0] wcnt_r;
	reg [3:0] wbeats_r;
	reg [`DCBC_BAW-1:0] wbank_r;
	reg [`DCBC_COLW-1:0] wcol_r;
	reg wap_r;
	reg [`DCBC_NBANK-1:0] wr_pend;
	wire f_ready;
	wire f_valid;
	wire [`DCBC_DW+`DCBC_BAW+`DCBC_COLW+1:0] f_out;
	wire beat = (ws_r == WS_DATA);
	wire last = beat && (wcnt_r == 4'h1);
	// Word: last, mask, bank, col, data
	wire [`DCBC_DW+`DCBC_BAW+`DCBC_COLW+1:0] f_in =
		{last & wap_r, i_dm, wbank_r, wcol_r, i_wdata};

	// Bursts are never cut: new write commands mid-burst are dropped
	always @(posedge i_clk) begin
		if (!i_reset_n) begin
			ws_r <= WS_IDLE;
			wcnt_r <= 4'h0;
			wbeats_r <= 4'h0;
			wbank_r <= {`DCBC_BAW{1'b0}};
			wcol_r <= {`DCBC_COLW{1'b0}};
			wap_r <= 1'b0;
		end else begin
			case (ws_r)
			WS_IDLE: begin
				if (is_wr) begin
					ws_r <= WS_LAT;
					wcnt_r <= `DCBC_CWL;
					wbeats_r <= bl8 ? `DCBC_BL8 : `DCBC_BC4;
					wbank_r <= i_ba;
					wcol_r <= i_addr[`DCBC_COLW-1:0];
					wap_r <= ap;
				end
			end
			WS_LAT: begin
				if (wcnt_r <= 4'h1) begin
					ws_r <= WS_DATA;
					wcnt_r <= wbeats_r + wbeats_r;
				end else
					wcnt_r <= wcnt_r - 4'h1;
			end
			WS_DATA: begin
				wcol_r <= wcol_r + {{(`DCBC_COLW-1){1'b0}}, 1'b1};
				if (wcnt_r <= 4'h1)
					ws_r <= WS_IDLE;
				else
					wcnt_r <= wcnt_r - 4'h1;
			end
			default: ws_r <= WS_IDLE;
			endcase
		end
	end

	dcbc_fifo #(
		.WIDTH(`DCBC_DW + `DCBC_BAW + `DCBC_COLW + 2),
		.DEPTH(`DCBC_FIFO_DEPTH),
		.AW(`DCBC_FIFO_AW)
	) u_wfifo (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_valid(beat),
		.o_ready(f_ready),
		.i_data(f_in),
		.o_valid(f_valid),
		.i_ready(i_arr_ready),
		.o_data(f_out)
	);

	// ------------------------------------------------------------
	// Array write and auto-precharge release
	// ------------------------------------------------------------
	wire f_pop = f_valid & i_arr_ready;
	wire f_mask = f_out[`DCBC_DW+`DCBC_BAW+`DCBC_COLW];
	wire f_last = f_out[`DCBC_DW+`DCBC_BAW+`DCBC_COLW+1];
	always @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_arr_we <= 1'b0;
			o_arr_bank <= {`DCBC_BAW{1'b0}};
			o_arr_row <= {`DCBC_ROWW{1'b0}};
			o_arr_col <= {`DCBC_COLW{1'b0}};
			o_arr_data <= {`DCBC_DW{1'b0}};
			wr_ap_done <= 1'b0;
			wr_ap_bank <= {`DCBC_BAW{1'b0}};
			o_wr_overflow <= 1'b0;
		end else begin
			o_arr_we <= f_pop & ~f_mask;
			if (f_pop) begin
				o_arr_bank <= f_out[`DCBC_DW+`DCBC_COLW+`DCBC_BAW-1:
					`DCBC_DW+`DCBC_COLW];
				o_arr_row <= brow_r[f_out[`DCBC_DW+`DCBC_COLW+
					`DCBC_BAW-1:`DCBC_DW+`DCBC_COLW]];
				o_arr_col <= f_out[`DCBC_DW+`DCBC_COLW-1:`DCBC_DW];
				o_arr_data <= f_out[`DCBC_DW-1:0];
			end
			// Close follows the stored last beat
			wr_ap_done <= f_pop & f_last;
			if (f_pop & f_last)
				wr_ap_bank <= f_out[`DCBC_DW+`DCBC_COLW+`DCBC_BAW-1:
					`DCBC_DW+`DCBC_COLW];
			// Beats lost when the array stalls too long; sticky
			if (beat & ~f_ready)
				o_wr_overflow <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Mode register write and status
	// ------------------------------------------------------------
	integer m;
	always @* begin
		for (m = 0; m < `DCBC_NBANK; m = m + 1)
			wr_pend[m] = (bst_r[m] == `DCBC_BK_ACT);
	end
	always @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_mrs_we <= 1'b0;
			o_mrs_sel <= 2'h0;
			o_mrs_val <= {`DCBC_ROWW{1'b0}};
			o_bank_open <= {`DCBC_NBANK{1'b0}};
			o_burst_busy <= 1'b0;
			o_self_refresh <= 1'b0;
			o_power_down <= 1'b0;
			o_odt_en <= 1'b0;
		end else begin
			o_mrs_we <= is_mrs;
			if (is_mrs) begin
				o_mrs_sel <= i_ba[1:0];
				o_mrs_val <= i_addr;
			end
			o_bank_open <= wr_pend;
			o_burst_busy <= (ws_r != WS_IDLE) | f_valid | rtp_busy_r;
			o_self_refresh <= sr_r;
			o_power_down <= pd_r;
			o_odt_en <= i_odt & ~sr_r;
		end
	end
	wire unused_ok = is_ref;
endmodule // dcbc_top

/* logic/dcbc_map.vh */
// Constants for the DDR3 command decode and bank control block
`ifndef DCBC_MAP_VH
`define DCBC_MAP_VH
// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define DCBC_NBANK 8
`define DCBC_BAW 3
`define DCBC_ROWW 16
`define DCBC_COLW 10
`define DCBC_DW 8
// ----------------------------------------------------------------
// Address bit positions
// ----------------------------------------------------------------
`define DCBC_AP_BIT 10
`define DCBC_BC_BIT 12
// ----------------------------------------------------------------
// Command codes {ras_n,cas_n,we_n}
// ----------------------------------------------------------------
`define DCBC_CMD_MRS 3'h0
`define DCBC_CMD_REF 3'h1
`define DCBC_CMD_PRE 3'h2
`define DCBC_CMD_ACT 3'h3
`define DCBC_CMD_WR 3'h4
`define DCBC_CMD_RD 3'h5
`define DCBC_CMD_ZQ 3'h6
`define DCBC_CMD_NOP 3'h7
// ----------------------------------------------------------------
// Bank states
// ----------------------------------------------------------------
`define DCBC_BK_IDLE 2'h0
`define DCBC_BK_ACT 2'h1
`define DCBC_BK_PRE 2'h2
// ----------------------------------------------------------------
// Timing in clock cycles, then write FIFO depth and address width
// ----------------------------------------------------------------
`define DCBC_TRP 4'h4
`define DCBC_TRAS 5'h0c
`define DCBC_TRTP 4'h2
`define DCBC_TWR 4'h6
`define DCBC_CWL 4'h5
`define DCBC_BL8 4'h4
`define DCBC_BC4 4'h2
`define DCBC_MAX_AL 4'h0
`define DCBC_FIFO_DEPTH 4
`define DCBC_FIFO_AW 2
`endif

/* verif/dcbc_chk_asserts.sv */
// Port checker for command decode and bank control
`timescale 1ns/10ps
`include "dcbc_map.vh"
module dcbc_chk (
	// Clock, reset, command pins
	input wire i_clk,
	input wire i_reset_n,
	input wire i_cke,
	input wire i_cs_n,
	input wire i_ras_n,
	input wire i_cas_n,
	input wire i_we_n,
	input wire [`DCBC_BAW-1:0] i_ba,
	input wire [`DCBC_ROWW-1:0] i_addr,
	// Outputs watched
	input wire o_rd_go,
	input wire [`DCBC_BAW-1:0] o_rd_bank,
	input wire [`DCBC_COLW-1:0] o_rd_col,
	input wire o_rd_bl8,
	input wire o_mrs_we,
	input wire [1:0] o_mrs_sel,
	input wire [`DCBC_ROWW-1:0] o_mrs_val,
	input wire [`DCBC_NBANK-1:0] o_bank_open,
	input wire o_self_refresh,
	input wire o_odt_en
);
	// ------
	// Decode
	// ------
	reg cke_q;
	reg [2:0] act_ba;
	wire [2:0] cmd = {i_ras_n, i_cas_n, i_we_n};
	wire tk = cke_q & i_cke & ~i_cs_n;
	wire rd = tk & (cmd == `DCBC_CMD_RD);
	wire mrs = tk & (cmd == `DCBC_CMD_MRS);
	wire act = tk & (cmd == `DCBC_CMD_ACT);
	// Bank of last activate, for the open check
	always @(posedge i_clk) begin
		if (!i_reset_n) begin
			cke_q <= 1'b1;
			act_ba <= 3'h0;
		end else begin
			cke_q <= i_cke;
			if (act) begin
				act_ba <= i_ba;
			end
		end
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	// ------
	// Checks
	// ------
	property p_rd_go;
		rd |=> o_rd_go;
	endproperty
	a_rd_go: assert property (p_rd_go)
		else $error("read not launched");
	property p_rd_only;
		o_rd_go |-> $past(rd);
	endproperty
	a_rd_only: assert property (p_rd_only)
		else $error("read launched without command");
	property p_rd_fields;
		rd |=> (o_rd_bank == $past(i_ba)) && (o_rd_col == $past(i_addr[9:0]))
			&& (o_rd_bl8 == $past(i_addr[`DCBC_BC_BIT]));
	endproperty
	a_rd_fields: assert property (p_rd_fields)
		else $error("read fields wrong");
	property p_mrs;
		mrs |=> o_mrs_we && (o_mrs_sel == $past(i_ba[1:0]))
			&& (o_mrs_val == $past(i_addr));
	endproperty
	a_mrs: assert property (p_mrs)
		else $error("mode write wrong");
	property p_mrs_only;
		o_mrs_we |-> $past(mrs);
	endproperty
	a_mrs_only: assert property (p_mrs_only)
		else $error("mode write without command");
	property p_act_open;
		act |-> ##[1:2] o_bank_open[act_ba];
	endproperty
	a_act_open: assert property (p_act_open)
		else $error("bank not opened");
	property p_odt;
		o_self_refresh && $past(o_self_refresh) |-> !o_odt_en;
	endproperty
	a_odt: assert property (p_odt)
		else $error("termination on in self refresh");
	property p_sr_exit;
		o_self_refresh && i_cke |-> ##[1:2] !o_self_refresh;
	endproperty
	a_sr_exit: assert property (p_sr_exit)
		else $error("self refresh not left");
endmodule // dcbc_chk

bind dcbc_top dcbc_chk u_chk (.i_clk, .i_reset_n, .i_cke, .i_cs_n,
	.i_ras_n, .i_cas_n, .i_we_n, .i_ba, .i_addr, .o_rd_go, .o_rd_bank,
	.o_rd_col, .o_rd_bl8, .o_mrs_we, .o_mrs_sel, .o_mrs_val, .o_bank_open,
	.o_self_refresh, .o_odt_en);

/* verif/dcbc_arr_model.sv */
// Array model behind the write port
`timescale 1ns/10ps
module dcbc_arr_model (
	// Clock and stall mode
	input wire i_clk,
	input wire [1:0] i_mode,
	// Array port
	input wire i_we,
	input wire [2:0] i_bank,
	input wire [15:0] i_row,
	input wire [9:0] i_col,
	input wire [7:0] i_data,
	output reg o_ready
);
	logic [7:0] mem [logic [28:0]];
	reg [1:0] ph = 2'h0;
	initial o_ready = 1'b0;
	// Mode 0 prompt, 1 random stall, 2 held off to fill the buffer
	// Mode 1 stalls at most one cycle in four so the buffer never fills
	always @(posedge i_clk) begin
		ph <= ph + 2'h1;
		o_ready <= (i_mode == 2'h0) | ((i_mode == 2'h1) &
			((ph != 2'h3) | ($urandom_range(1) == 1)));
		if (i_we) begin
			mem[{i_bank, i_row, i_col}] = i_data;
		end
	end
endmodule // dcbc_arr_model

/* verif/dcbc_bench.sv */
// Self-checking bench for command decode and bank control
`timescale 1ns/10ps
`include "dcbc_map.vh"
module dcbc_bench;
	reg i_clk = 1'b0, i_reset_n = 1'b0, i_cke = 1'b1, i_cs_n = 1'b1;
	reg i_ras_n = 1'b1, i_cas_n = 1'b1, i_we_n = 1'b1;
	reg i_odt = 1'b0, i_dm = 1'b1;
	reg [2:0] i_ba = 3'h0;
	reg [15:0] i_addr = 16'h0000;
	reg [3:0] i_al = 4'h0;
	reg [7:0] i_wdata = 8'h00;
	reg [1:0] mode = 2'h0;
	wire i_arr_ready, o_arr_we, o_rd_go, o_rd_bl8, o_mrs_we, o_burst_busy;
	wire o_self_refresh, o_power_down, o_odt_en, o_wr_overflow;
	wire [2:0] o_arr_bank, o_rd_bank;
	wire [15:0] o_arr_row, o_rd_row, o_mrs_val;
	wire [9:0] o_arr_col, o_rd_col;
	wire [7:0] o_arr_data, o_bank_open;
	wire [1:0] o_mrs_sel;
	integer bad_count = 0, compares = 0, cyc = 0, v, j;
	reg [7:0] exp_b [0:7];
	reg [7:0] dmv;
	reg [15:0] row;
	reg [9:0] col;
	dcbc_top dut (.i_clk, .i_reset_n, .i_cke, .i_cs_n, .i_ras_n, .i_cas_n,
		.i_we_n, .i_odt, .i_ba, .i_addr, .i_al, .i_wdata, .i_dm, .o_arr_we,
		.o_arr_bank, .o_arr_row, .o_arr_col, .o_arr_data, .i_arr_ready,
		.o_rd_go, .o_rd_bank, .o_rd_row, .o_rd_col, .o_rd_bl8, .o_mrs_we,
		.o_mrs_sel, .o_mrs_val, .o_bank_open, .o_burst_busy, .o_self_refresh,
		.o_power_down, .o_odt_en, .o_wr_overflow);
	dcbc_arr_model u_arr (.i_clk, .i_mode(mode), .i_we(o_arr_we),
		.i_bank(o_arr_bank), .i_row(o_arr_row), .i_col(o_arr_col),
		.i_data(o_arr_data), .o_ready(i_arr_ready));
	always #25 i_clk = ~i_clk;
	// Run is about 1000 cycles; ceiling leaves ample margin
	always @(posedge i_clk) begin
		cyc = cyc + 1;
		if (cyc == 5000) begin
			bad_count = bad_count + 1;
			tally_and_finish;
		end
	end
	// -----
	// Tasks
	// -----
	task chk(input [15:0] got, input [15:0] exp);
		begin
			compares = compares + 1;
			if (got !== exp) begin
				bad_count = bad_count + 1;
				$display("[FAIL] %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task tally_and_finish;
		begin
			$display("mismatches %0d compares %0d", bad_count, compares);
			if (bad_count == 0 && compares > 0) begin
				$display("SIMULATION PASSED");
			end else begin
				$display("SIMULATION FAILED");
			end
			$finish;
		end
	endtask
	// Deselect after each command carries junk to prove it is ignored
	task issue(input [2:0] c, input [2:0] b, input [15:0] a);
		begin
			@(posedge i_clk);
			i_cke <= (c != `DCBC_CMD_REF);
			i_cs_n <= 1'b0;
			{i_ras_n, i_cas_n, i_we_n} <= c;
			i_ba <= b;
			i_addr <= a;
			@(posedge i_clk);
			i_cs_n <= 1'b1;
			{i_ras_n, i_cas_n, i_we_n} <= 3'($urandom);
			i_addr <= 16'($urandom);
		end
	endtask
	task wr(input [2:0] b, input ap, input l8, input mk);
		begin
			col = 10'($urandom) & 10'h3f8;
			issue(`DCBC_CMD_WR, b, {3'h0, l8, 1'b0, ap, col});
			repeat (`DCBC_CWL) @(posedge i_clk);
			for (j = 0; j < (l8 ? 8 : 4); j = j + 1) begin
				exp_b[j] = 8'($urandom);
				dmv[j] = mk & ((j == 1) | ((j > 1) & ($urandom_range(1) == 1)));
				i_wdata <= exp_b[j];
				i_dm <= dmv[j];
				i_cs_n <= (j != 2);
				{i_ras_n, i_cas_n, i_we_n} <= `DCBC_CMD_WR;
				@(posedge i_clk);
			end
			i_dm <= 1'b1;
			i_cs_n <= 1'b1;
		end
	endtask
	task wr_chk(input [2:0] b, input integer n);
		reg [28:0] k;
		reg [15:0] g, e, ok;
		begin
			ok = 16'h0000;
			for (j = 0; j < n; j = j + 1) begin
				k = {b, row, col + 10'(j)};
				g = u_arr.mem.exists(k) ? {8'h00, u_arr.mem[k]} : 16'hffff;
				e = dmv[j] ? 16'hffff : {8'h00, exp_b[j]};
				ok = ok + {15'h0000, !dmv[j]};
				chk(g, e);
			end
			chk(16'(u_arr.mem.size()), ok);
		end
	endtask
	// ---------
	// Main flow
	// ---------
	initial begin
		void'($urandom(31637));
		repeat (2) @(posedge i_clk);
		chk({8'h00, o_bank_open}, 16'h0000);
		i_reset_n <= 1'b1;
		for (v = 0; v < 4; v = v + 1) begin
			row = 16'($urandom);
			issue(`DCBC_CMD_MRS, v[2:0], row);
			repeat (4) @(posedge i_clk);
			chk({14'h0000, o_mrs_sel}, {14'h0000, v[1:0]});
			chk(o_mrs_val, row);
		end
		// Reads: chopped, full, auto close, auto close on young row
		for (v = 0; v < 4; v = v + 1) begin
			row = 16'($urandom);
			i_al <= {2'h0, v[1], 1'b0};
			issue(`DCBC_CMD_ACT, v[2:0], row);
			repeat ((v == 3) ? 1 : 14) @(posedge i_clk);
			col = 10'($urandom);
			issue(`DCBC_CMD_RD, v[2:0], {3'h0, v[0], 1'b0, v[1], col});
			repeat (3) @(posedge i_clk);
			chk(o_bank_open[v], 1'b1);
			repeat (3) @(posedge i_clk);
			chk({o_rd_bank, o_rd_col}, {v[2:0], col});
			chk(o_rd_bl8, v[0]);
			chk(o_rd_row, row);
			chk(o_bank_open[v], v != 2);
			repeat (16) @(posedge i_clk);
			chk(o_bank_open[v], !v[1]);
			if (!v[1]) issue(`DCBC_CMD_PRE, v[2:0], 16'h0000);
			repeat (6) @(posedge i_clk);
		end
		for (v = 0; v < 8; v = v + 1) begin
			issue(`DCBC_CMD_ACT, v[2:0], 16'($urandom));
			repeat (6) @(posedge i_clk);
		end
		repeat (14) @(posedge i_clk);
		chk({8'h00, o_bank_open}, 16'h00ff);
		for (v = 0; v < 3; v = v + 1) begin
			issue(`DCBC_CMD_PRE, 3'h5, {5'h00, v == 2, 10'h000});
			repeat (6) @(posedge i_clk);
			chk({8'h00, o_bank_open}, (v == 2) ? 16'h0 : 16'h00df);
		end
		i_odt <= 1'b1;
		repeat (3) @(posedge i_clk);
		chk(o_odt_en, 1'b1);
		issue(`DCBC_CMD_REF, 3'h0, 16'h0000);
		repeat (4) @(posedge i_clk);
		chk(o_self_refresh, 1'b1);
		chk(o_odt_en, 1'b0);
		i_cke <= 1'b1;
		repeat (4) @(posedge i_clk);
		chk(o_self_refresh, 1'b0);
		repeat (512) @(posedge i_clk);
		i_cke <= 1'b0;
		repeat (4) @(posedge i_clk);
		chk(o_power_down, 1'b1);
		i_cke <= 1'b1;
		repeat (4) @(posedge i_clk);
		chk(o_power_down, 1'b0);
		// Writes with a stalling array: chopped open, full auto close
		mode <= 2'h1;
		row = 16'($urandom);
		issue(`DCBC_CMD_ACT, 3'h2, row);
		repeat (14) @(posedge i_clk);
		for (v = 0; v < 2; v = v + 1) begin
			u_arr.mem.delete();
			wr(3'h2, v[0], v[0], 1'b1);
			repeat (30) @(posedge i_clk);
			wr_chk(3'h2, v ? 8 : 4);
			chk(o_bank_open[2], !v[0]);
		end
		// Array held off: buffer fills, later beats lost, then drains
		mode <= 2'h2;
		issue(`DCBC_CMD_ACT, 3'h6, row);
		repeat (14) @(posedge i_clk);
		u_arr.mem.delete();
		wr(3'h6, 1'b0, 1'b1, 1'b0);
		repeat (4) @(posedge i_clk);
		chk(o_wr_overflow, 1'b1);
		chk(o_burst_busy, 1'b1);
		mode <= 2'h0;
		repeat (30) @(posedge i_clk);
		chk({8'h00, u_arr.mem[{3'h6, row, col}]}, {8'h00, exp_b[0]});
		chk(16'(u_arr.mem.exists({3'h6, row, col + 10'h7})), 16'h0);
		chk(o_burst_busy, 1'b0);
		tally_and_finish;
	end
endmodule // dcbc_bench
